//--- core/asc_map.vh
`ifndef ASC_MAP_VH
`define ASC_MAP_VH

// Bus offsets (byte addresses)
`define ASC_OFF_CTRL 8'h00
`define ASC_OFF_DATA 8'h04

// Pointer/command register fields
`define ASC_PTR_LSB 0
`define ASC_CMD_LSB 3
`define ASC_CMD_RST_EXT 3'h2
`define ASC_CMD_CHAN_RST 3'h3
`define ASC_CMD_ERR_RST 3'h6

// Register pointer values
`define ASC_REG_OPT 3'h1
`define ASC_REG_VEC 3'h2
`define ASC_REG_RXP 3'h3
`define ASC_REG_FMT 3'h4
`define ASC_REG_TXP 3'h5

// Receive params fields
`define ASC_RXP_EN 0
`define ASC_RXP_AUTO 5
`define ASC_RXP_BITS 6

// Format params fields
`define ASC_FMT_PAR_EN 0
`define ASC_FMT_PAR_EVEN 1
`define ASC_FMT_STOP 2
`define ASC_FMT_DIV 6

// Transmit params fields
`define ASC_TXP_RTS 1
`define ASC_TXP_EN 3
`define ASC_TXP_BRK 4
`define ASC_TXP_BITS 5
`define ASC_TXP_DTR 7

// Stop bit codes
`define ASC_STOP_1 2'h1
`define ASC_STOP_15 2'h2

// Reset values
`define ASC_RST_REG 8'h00
`define ASC_RST_VEC 8'h00

// Receive buffer depth
`define ASC_RX_DEPTH 2'h3

`endif

//--- core/asc_sync.v
// Two-stage pin synchroniser
module asc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire i_clk,
    input wire i_rstn,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= INIT;
            o_sync <= INIT;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule

//--- core/asc_channel.v
// Function
// RULE1: bit clock divided by 1, 16, 32 or 64.
// RULE2: receiver and transmitter share one divide factor.
// RULE3: x1 needs receive clock aligned to data bits.
// RULE4: system clock never sets bit rate.
// RULE5: with auto enables, carrier detect low enables the receiver.
// RULE6: with auto enables, clear-to-send low enables the transmitter.
// RULE7: missing stop bit after parity or last data bit flags framing.
// RULE8: assembly starts at a start bit; start bit not framing-checked.
// RULE9: ones count against odd/even choice flags parity.
// RULE10: three-character buffer; overflow sets overrun, replaces newest.
// RULE11: each receive error sets its own status bit.
// RULE12: request-to-send, terminal-ready outputs set by software.
// RULE13: sync pin is a spare software-readable input.
// RULE14: carrier and clear-to-send status read inverted from pins.
// RULE15: continuous spacing on receive line reports break.
// RULE16: any edge on carrier, clear-to-send or break latches status.
// RULE17: latched status holds until reset-external-status command.
// RULE18: vector register exists only in channel B.
// RULE19: registers loaded as pointer byte then value byte.
// RULE20: status registers 0 to 2; register 2 only in channel B.
// RULE21: software resets, then loads format, receive, transmit params.
// RULE22: software loads vector and options for interrupt mode.
// RULE23: sync character registers have no effect.
// RULE24: 5 to 8 bits per character, receive and transmit separate.
// RULE25: transmitter sends start bit and 1, 1.5 or 2 stop bits.
// RULE26: receiver checks exactly one stop bit.
// RULE27: received byte holds data, then parity and stop, rest filled.
// RULE28: line idles at mark when nothing is sent.
// RULE29: receive error bits hold until error-reset command.
`include "asc_map.vh"

module asc_channel #(
    parameter CHANNEL_B = 1,
    parameter AW = 8
) (
    input wire I_CLK_SYS,
    input wire I_RSTN,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [AW-1:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output wire O_PREADY,
    output reg O_PSLVERR,
    input wire I_RX_BIT_CLOCK,
    input wire I_TX_BIT_CLOCK,
    input wire I_RXD,
    output reg O_TXD,
    input wire I_DCD_N,
    input wire I_CTS_N,
    input wire I_SYNC_N,
    output wire O_RTS_N,
    output wire O_DTR_N,
    output wire [7:0] O_INT_OPTIONS
);

    localparam S_IDLE = 5'h01;
    localparam S_START = 5'h02;
    localparam S_DATA = 5'h04;
    localparam S_PAR = 5'h08;
    localparam S_STOP = 5'h10;

    // Divide factor from mode code
    function [6:0] div_of;
        input [1:0] code;
        begin
            case (code)
                2'h0: div_of = 7'h01;
                2'h1: div_of = 7'h10;
                2'h2: div_of = 7'h20;
                default: div_of = 7'h40;
            endcase
        end
    endfunction

    // Character length from code
    function [3:0] bits_of;
        input [1:0] code;
        begin
            bits_of = {2'h0, code} + 4'h5;
        end
    endfunction

    // Pin synchronisers; pins idle high
    wire [5:0] pins_s;
    asc_sync #(.WIDTH(6), .INIT(6'h3f)) u_sync (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_async({I_RX_BIT_CLOCK, I_TX_BIT_CLOCK, I_RXD,
                  I_DCD_N, I_CTS_N, I_SYNC_N}),
        .o_sync(pins_s)
    );
    wire rxc_s = pins_s[5];
    wire txc_s = pins_s[4];
    wire rxd_s = pins_s[3];
    wire dcd_n_s = pins_s[2];
    wire cts_n_s = pins_s[1];
    wire sync_n_s = pins_s[0];

    reg rxc_prev_q;
    reg txc_prev_q;
    // Bit clock rising edges are ticks
    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rxc_prev_q <= 1'b1;
            txc_prev_q <= 1'b1;
        end else begin
            rxc_prev_q <= rxc_s;
            txc_prev_q <= txc_s;
        end
    end
    wire rx_tick = rxc_s & ~rxc_prev_q; // [RULE4]
    wire tx_tick = txc_s & ~txc_prev_q; // [RULE4]

    // Bus decode
    wire setup = I_PSEL & ~I_PENABLE;
    wire acc = I_PSEL & I_PENABLE;
    wire sel_ctrl = (I_PADDR == `ASC_OFF_CTRL);
    wire sel_data = (I_PADDR == `ASC_OFF_DATA);
    wire [7:0] wd = I_PWDATA[7:0];
    wire wr_ctrl = acc & I_PWRITE & sel_ctrl;
    wire rd_ctrl = acc & ~I_PWRITE & sel_ctrl;
    wire wr_data = acc & I_PWRITE & sel_data;
    wire rd_data = acc & ~I_PWRITE & sel_data;
    assign O_PREADY = 1'b1;

    reg [2:0] ptr_q;
    wire [2:0] cmd = wd[`ASC_CMD_LSB+2:`ASC_CMD_LSB];
    wire cmd_ok = wr_ctrl & (ptr_q == 3'h0);
    wire chan_rst = cmd_ok & (cmd == `ASC_CMD_CHAN_RST);
    wire ext_rst = cmd_ok & (cmd == `ASC_CMD_RST_EXT);
    wire err_rst = cmd_ok & (cmd == `ASC_CMD_ERR_RST);

    reg [7:0] opt_q;
    reg [7:0] vec_q;
    reg [7:0] rxp_q;
    reg [7:0] fmt_q;
    reg [7:0] txp_q;

    // Pointer, then value; pointer clears after use
    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ptr_q <= 3'h0;
            opt_q <= `ASC_RST_REG;
            vec_q <= `ASC_RST_VEC;
            rxp_q <= `ASC_RST_REG;
            fmt_q <= `ASC_RST_REG;
            txp_q <= `ASC_RST_REG;
        end else if (chan_rst) begin
            ptr_q <= 3'h0;
            opt_q <= `ASC_RST_REG;
            rxp_q <= `ASC_RST_REG;
            fmt_q <= `ASC_RST_REG;
            txp_q <= `ASC_RST_REG;
        end else if (wr_ctrl) begin
            if (ptr_q == 3'h0) begin
                ptr_q <= wd[`ASC_PTR_LSB+2:`ASC_PTR_LSB]; // [RULE19]
            end else begin
                ptr_q <= 3'h0; // [RULE19]
                case (ptr_q)
                    `ASC_REG_OPT: opt_q <= wd;
                    `ASC_REG_VEC: if (CHANNEL_B != 0) vec_q <= wd; // [RULE18]
                    `ASC_REG_RXP: rxp_q <= wd;
                    `ASC_REG_FMT: fmt_q <= wd;
                    `ASC_REG_TXP: txp_q <= wd;
                    default: ; // Sync chars ignored [RULE23]
                endcase
            end
        end else if (rd_ctrl) begin
            ptr_q <= 3'h0;
        end
    end

    assign O_INT_OPTIONS = opt_q;
    // Modem outputs, active low pins
    assign O_RTS_N = ~txp_q[`ASC_TXP_RTS]; // [RULE12]
    assign O_DTR_N = ~txp_q[`ASC_TXP_DTR]; // [RULE12]

    // One factor serves both directions
    wire [6:0] div = // [RULE1] [RULE2]
        div_of(fmt_q[`ASC_FMT_DIV+1:`ASC_FMT_DIV]);
    wire [6:0] half = {1'b0, div[6:1]};
    wire par_en = fmt_q[`ASC_FMT_PAR_EN];
    wire par_even = fmt_q[`ASC_FMT_PAR_EVEN];
    wire auto_en = rxp_q[`ASC_RXP_AUTO];
    wire [3:0] rx_bits = // [RULE24]
        bits_of(rxp_q[`ASC_RXP_BITS+1:`ASC_RXP_BITS]);
    wire [3:0] tx_bits = // [RULE24]
        bits_of(txp_q[`ASC_TXP_BITS+1:`ASC_TXP_BITS]);
    wire rx_on = rxp_q[`ASC_RXP_EN] & (~auto_en | ~dcd_n_s); // [RULE5]
    wire tx_on = txp_q[`ASC_TXP_EN] & (~auto_en | ~cts_n_s); // [RULE6]

    // Receiver
    reg [4:0] rx_st_q;
    reg [6:0] rx_cnt_q;
    reg [3:0] rx_pos_q;
    reg [3:0] rx_idx_q;
    reg [7:0] rx_byte_q;
    reg rx_par_q;
    reg rx_push_q;
    reg rx_pe_q;
    reg rx_fe_q;
    reg brk_q;
    wire rx_mid = rx_tick & (rx_cnt_q == div - 7'h01);

    // Character assembly; one in flight finishes if disabled
    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rx_st_q <= S_IDLE;
            rx_cnt_q <= 7'h00;
            rx_pos_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_byte_q <= 8'h00;
            rx_par_q <= 1'b0;
            rx_push_q <= 1'b0;
            rx_pe_q <= 1'b0;
            rx_fe_q <= 1'b0;
            brk_q <= 1'b0;
        end else if (chan_rst) begin
            rx_st_q <= S_IDLE;
            rx_push_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            rx_push_q <= 1'b0;
            if (rx_tick)
                rx_cnt_q <= rx_cnt_q + 7'h01;
            case (rx_st_q)
                S_IDLE: begin
                    rx_cnt_q <= 7'h00;
                    rx_pos_q <= 4'h0;
                    rx_idx_q <= 4'h0;
                    rx_byte_q <= 8'h00;
                    rx_par_q <= 1'b0;
                    // Break ends when line marks
                    if (brk_q) begin
                        if (rx_tick & rxd_s)
                            brk_q <= 1'b0; // [RULE15]
                    end else if (rx_on & rx_tick & ~rxd_s) begin
                        rx_st_q <= div == 7'h01 ? S_DATA : S_START; // [RULE8]
                    end
                end
                S_START: begin
                    // Mid start recheck rejects glitches
                    if (rx_tick & (rx_cnt_q + 7'h01 >= half)) begin
                        rx_cnt_q <= 7'h00;
                        rx_st_q <= rxd_s ? S_IDLE : S_DATA; // [RULE8]
                    end
                end
                S_DATA: begin
                    if (rx_mid) begin
                        rx_cnt_q <= 7'h00;
                        rx_byte_q[rx_pos_q[2:0]] <= rxd_s; // [RULE27]
                        rx_pos_q <= rx_pos_q + 4'h1;
                        rx_idx_q <= rx_idx_q + 4'h1;
                        rx_par_q <= rx_par_q ^ rxd_s;
                        if (rx_idx_q == rx_bits - 4'h1)
                            rx_st_q <= par_en ? S_PAR : S_STOP;
                    end
                end
                S_PAR: begin
                    if (rx_mid) begin
                        rx_cnt_q <= 7'h00;
                        if (rx_pos_q < 4'h8)
                            rx_byte_q[rx_pos_q[2:0]] <= rxd_s; // [RULE27]
                        rx_pos_q <= rx_pos_q + 4'h1;
                        rx_par_q <= rx_par_q ^ rxd_s;
                        rx_st_q <= S_STOP;
                    end
                end
                S_STOP: begin
                    // Only one stop bit is ever checked
                    if (rx_mid) begin
                        if (rx_pos_q < 4'h8)
                            rx_byte_q[rx_pos_q[2:0]] <= rxd_s; // [RULE27]
                        rx_fe_q <= ~rxd_s; // [RULE7] [RULE26]
                        rx_pe_q <= par_en & (rx_par_q ^ ~par_even); // [RULE9]
                        // Null char without stop bit is break
                        brk_q <= ~rxd_s & (rx_byte_q == 8'h00); // [RULE15]
                        rx_push_q <= 1'b1;
                        rx_st_q <= S_IDLE;
                    end
                end
                default: rx_st_q <= S_IDLE;
            endcase
        end
    end

    // Three-deep receive buffer
    reg [7:0] buf_q [0:2];
    reg [1:0] cnt_q;
    reg ovr_q;
    reg pe_q;
    reg fe_q;
    wire pop = rd_data & (cnt_q != 2'h0);
    wire [1:0] cnt_pop = pop ? cnt_q - 2'h1 : cnt_q;
    wire full_push = rx_push_q & (cnt_pop == `ASC_RX_DEPTH);

    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cnt_q <= 2'h0;
            buf_q[0] <= 8'h00;
            buf_q[1] <= 8'h00;
            buf_q[2] <= 8'h00;
        end else if (chan_rst) begin
            cnt_q <= 2'h0;
        end else begin
            if (pop) begin
                buf_q[0] <= buf_q[1];
                buf_q[1] <= buf_q[2];
            end
            if (full_push) begin
                buf_q[2] <= rx_byte_q; // Newest overwritten [RULE10]
                cnt_q <= cnt_pop;
            end else if (rx_push_q) begin
                buf_q[cnt_pop] <= rx_byte_q;
                cnt_q <= cnt_pop + 2'h1;
            end else begin
                cnt_q <= cnt_pop;
            end
        end
    end

    // Sticky errors; a new error beats a same-cycle error reset
    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ovr_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
        end else if (chan_rst) begin
            ovr_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
        end else begin
            ovr_q <= (ovr_q & ~err_rst) | full_push; // [RULE10] [RULE29]
            pe_q <= (pe_q & ~err_rst) | (rx_push_q & rx_pe_q); // [RULE11]
            fe_q <= (fe_q & ~err_rst) | (rx_push_q & rx_fe_q); // [RULE11]
        end
    end

    // External status latch
    wire [2:0] ext_live = {brk_q, ~cts_n_s, ~dcd_n_s}; // [RULE14]
    reg [2:0] ext_q;
    reg ext_lat_q;
    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ext_q <= 3'h0;
            ext_lat_q <= 1'b0;
        end else if (ext_rst | chan_rst) begin
            ext_q <= ext_live; // [RULE17]
            ext_lat_q <= 1'b0;
        end else if (~ext_lat_q & (ext_live != ext_q)) begin
            ext_q <= ext_live; // [RULE16]
            ext_lat_q <= 1'b1; // Frozen until reset [RULE17]
        end
    end

    // Transmitter
    reg [4:0] tx_st_q;
    reg [6:0] tx_cnt_q;
    reg [3:0] tx_idx_q;
    reg [7:0] tx_sh_q;
    reg [7:0] tx_buf_q;
    reg tx_full_q;
    reg tx_par_q;
    wire [1:0] stop_code = fmt_q[`ASC_FMT_STOP+1:`ASC_FMT_STOP];
    // Stop ticks; 1.5 at x1 is one bit
    wire [7:0] stop_lim = (stop_code == `ASC_STOP_1) ? {1'b0, div} :
                          (stop_code == `ASC_STOP_15) ?
                          {1'b0, div} + {1'b0, half} : {div, 1'b0};
    wire tx_end = tx_tick & (tx_cnt_q == div - 7'h01);
    wire tx_load = tx_tick & tx_on & tx_full_q & tx_st_q[0];

    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tx_st_q <= S_IDLE;
            tx_cnt_q <= 7'h00;
            tx_idx_q <= 4'h0;
            tx_sh_q <= 8'h00;
            tx_par_q <= 1'b0;
            O_TXD <= 1'b1;
        end else if (chan_rst) begin
            tx_st_q <= S_IDLE;
            O_TXD <= 1'b1;
        end else begin
            if (tx_tick)
                tx_cnt_q <= tx_cnt_q + 7'h01;
            case (tx_st_q)
                S_IDLE: begin
                    tx_cnt_q <= 7'h00;
                    tx_idx_q <= 4'h0;
                    O_TXD <= ~txp_q[`ASC_TXP_BRK]; // Mark or break [RULE28]
                    if (tx_load) begin
                        tx_sh_q <= tx_buf_q;
                        tx_par_q <= ~par_even;
                        O_TXD <= 1'b0; // [RULE25]
                        tx_st_q <= S_START;
                    end
                end
                S_START: begin
                    if (tx_end) begin
                        tx_cnt_q <= 7'h00;
                        O_TXD <= tx_sh_q[0];
                        tx_st_q <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (tx_end) begin
                        tx_cnt_q <= 7'h00;
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_idx_q <= tx_idx_q + 4'h1;
                        if (tx_idx_q == tx_bits - 4'h1) begin
                            O_TXD <= par_en ? tx_par_q ^ tx_sh_q[0] : 1'b1;
                            tx_st_q <= par_en ? S_PAR : S_STOP;
                        end else begin
                            O_TXD <= tx_sh_q[1];
                        end
                    end
                end
                S_PAR: begin
                    if (tx_end) begin
                        tx_cnt_q <= 7'h00;
                        O_TXD <= 1'b1;
                        tx_st_q <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (tx_tick & ({1'b0, tx_cnt_q} == stop_lim - 8'h01)) begin
                        tx_st_q <= S_IDLE; // [RULE25]
                    end
                end
                default: tx_st_q <= S_IDLE;
            endcase
        end
    end

    // Holding buffer; writes when full are lost
    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tx_buf_q <= 8'h00;
            tx_full_q <= 1'b0;
        end else if (chan_rst) begin
            tx_full_q <= 1'b0;
        end else if (wr_data & ~tx_full_q) begin
            tx_buf_q <= wd;
            tx_full_q <= 1'b1;
        end else if (tx_load) begin
            tx_full_q <= 1'b0;
        end
    end

    // Status views
    wire all_sent = tx_st_q[0] & ~tx_full_q;
    wire [7:0] rr0 = {ext_q[2], 1'b0, ext_q[1], ~sync_n_s, ext_q[0],
                      ~tx_full_q, 1'b0, cnt_q != 2'h0}; // [RULE13] [RULE14]
    wire [7:0] rr1 = {1'b0, fe_q, ovr_q, pe_q, 3'h0, all_sent}; // [RULE11]
    wire [7:0] rr2 = (CHANNEL_B != 0) ? vec_q : 8'h00; // [RULE20]
    reg [7:0] rd_sel;

    always @* begin
        case (ptr_q)
            3'h0: rd_sel = rr0;
            3'h1: rd_sel = rr1;
            3'h2: rd_sel = rr2; // [RULE20]
            default: rd_sel = 8'h00;
        endcase
    end

    // Read data loaded at setup, a flop by access
    always @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else if (setup) begin
            O_PSLVERR <= ~(sel_ctrl | sel_data);
            if (I_PWRITE | ~(sel_ctrl | sel_data))
                O_PRDATA <= 32'h0000_0000;
            else if (sel_ctrl)
                O_PRDATA <= {24'h00_0000, rd_sel};
            else
                O_PRDATA <= {24'h00_0000, buf_q[0]};
        end
    end

endmodule

//--- dv/asc_chk.sv
`include "asc_map.vh"

module asc_chk #(
    parameter AW = 8
) (
    input wire I_CLK_SYS,
    input wire I_RSTN,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [AW-1:0] I_PADDR,
    input wire [31:0] O_PRDATA,
    input wire O_PREADY,
    input wire O_PSLVERR,
    input wire O_TXD,
    input wire O_RTS_N,
    input wire O_DTR_N,
    input wire [7:0] O_INT_OPTIONS
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus view
    wire acc = I_PSEL && I_PENABLE;
    wire wr_acc = acc && I_PWRITE;
    wire hit = I_PADDR == `ASC_OFF_CTRL || I_PADDR == `ASC_OFF_DATA;
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RSTN);
    a_ready_high: assert property (acc |-> O_PREADY)
        else $error("ready low");
    a_err_unmapped: assert property (acc && !hit |-> O_PSLVERR)
        else $error("no error on miss");
    a_err_mapped: assert property (acc && hit |-> !O_PSLVERR)
        else $error("error on hit");
    a_rd_byte: assert property (
        acc && !I_PWRITE |-> O_PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    // Outputs move only on writes
    a_rts_cause: assert property (
        $changed(O_RTS_N) |-> $past(wr_acc)) else $error("rts moved alone");
    a_dtr_cause: assert property (
        $changed(O_DTR_N) |-> $past(wr_acc)) else $error("dtr moved alone");
    a_opts_cause: assert property (
        $changed(O_INT_OPTIONS) |-> $past(wr_acc))
        else $error("options moved alone");
    // Line marks after reset
    a_mark_reset: assert property ($rose(I_RSTN) |-> O_TXD [*3])
        else $error("no mark after reset");
    a_ctrl_reset: assert property (
        $rose(I_RSTN) |-> O_RTS_N && O_DTR_N && O_INT_OPTIONS == 8'h00)
        else $error("outputs not idle");
    c_unmapped: cover property (acc && !hit);
    c_tx_start: cover property ($fell(O_TXD));
    c_rts_on: cover property ($fell(O_RTS_N));
endmodule

bind asc_channel asc_chk #(.AW(AW)) i_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_TXD(O_TXD), .O_RTS_N(O_RTS_N), .O_DTR_N(O_DTR_N),
    .O_INT_OPTIONS(O_INT_OPTIONS));

//--- dv/asc_modem.sv
module asc_modem (
    input wire i_txd,
    output logic o_rxd,
    output logic o_rx_clk,
    output logic o_tx_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RXH = 20;
    localparam int TXH = 25;
    // Free-running bit clocks
    initial begin
        o_rxd = 1'b1;
        o_rx_clk = 1'b0;
        forever #RXH o_rx_clk = ~o_rx_clk;
    end
    initial begin
        o_tx_clk = 1'b0;
        #3;
        forever #TXH o_tx_clk = ~o_tx_clk;
    end
    // Frame LSB first; unaligned clock, so never x1
    task automatic send(input logic [9:0] f, input int n, div);
        o_rxd = 1'b0;
        #(2 * RXH * div);
        for (int i = 0; i < n; i++) begin
            o_rxd = f[i];
            #(2 * RXH * div);
        end
        o_rxd = 1'b1;
        #(2 * RXH * div);
    endtask
    // Mid-bit samples from start edge
    task automatic recv(output logic [7:0] d, input int n, div);
        d = 8'h00;
        @(negedge i_txd);
        #(3 * TXH * div);
        for (int i = 0; i < n; i++) begin
            d[i] = i_txd;
            #(2 * TXH * div);
        end
    endtask
endmodule

//--- dv/test_async_serial_channel.sv
`include "asc_map.vh"

module test_async_serial_channel;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [1:0] div, bits;
        logic pe, ev;
        logic [7:0] d, rx;
    } asc_row_t;
    asc_row_t rows [4] = '{'{2'h1, 2'h3, 1'b0, 1'b0, 8'ha5, 8'ha5},
        '{2'h2, 2'h0, 1'b1, 1'b1, 8'h16, 8'h76},
        '{2'h3, 2'h2, 1'b1, 1'b0, 8'h41, 8'hc1},
        '{2'h1, 2'h1, 1'b0, 1'b0, 8'h2b, 8'h6b}};
    logic [7:0] ovr [3] = '{8'h11, 8'h22, 8'h44};
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic dcd_n = 1'b1, cts_n = 1'b1, sync_n = 1'b1, err, par;
    logic [7:0] paddr = 8'h00, rd, got;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire [7:0] opts;
    wire pready, pslverr, txd, rxd, rxc, txc, rts_n, dtr_n;
    int fails = 0, check_count = 0, cyc = 0, nb, dv;
    asc_channel #(.CHANNEL_B(1), .AW(8)) i_dut (
        .I_CLK_SYS(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_RX_BIT_CLOCK(rxc), .I_TX_BIT_CLOCK(txc), .I_RXD(rxd),
        .O_TXD(txd), .I_DCD_N(dcd_n), .I_CTS_N(cts_n), .I_SYNC_N(sync_n),
        .O_RTS_N(rts_n), .O_DTR_N(dtr_n), .O_INT_OPTIONS(opts));
    asc_modem i_modem (.i_txd(txd), .o_rxd(rxd), .o_rx_clk(rxc),
        .o_tx_clk(txc));
    // 200 MHz system clock
    initial forever #2.5 clk = ~clk;
    // Hang guard; run needs ~35k
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Held until pready seen
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Pointer byte, then value
    task automatic wreg(input logic [2:0] p, input logic [7:0] v);
        apb(1'b1, `ASC_OFF_CTRL, {5'h00, p});
        apb(1'b1, `ASC_OFF_CTRL, v);
    endtask
    task automatic rreg(input logic [2:0] p);
        apb(1'b1, `ASC_OFF_CTRL, {5'h00, p});
        apb(1'b0, `ASC_OFF_CTRL, 8'h00);
    endtask
    task automatic cmd(input logic [2:0] c);
        apb(1'b1, `ASC_OFF_CTRL, {2'b00, c, 3'b000});
    endtask
    task automatic init(input logic [7:0] f, r, t);
        cmd(`ASC_CMD_CHAN_RST);
        wreg(`ASC_REG_FMT, f);
        wreg(`ASC_REG_RXP, r);
        wreg(`ASC_REG_TXP, t);
        wreg(3'h6, 8'hff);
        wreg(3'h7, 8'hff);
    endtask
    task automatic tx_char(input logic [7:0] d, input logic pe, p, s);
        logic [9:0] f;
        f = {2'b00, d} | ({9'h0, p & pe} << nb) | ({9'h0, s} << (nb + pe));
        i_modem.send(f, nb + pe + 1, dv);
    endtask
    // Table rows, then awkward cases
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[k]) begin
            nb = 5 + rows[k].bits;
            dv = 8 << rows[k].div;
            par = rows[k].ev ? ^rows[k].d : ~^rows[k].d;
            init({rows[k].div, 4'h1, rows[k].ev, rows[k].pe},
                {rows[k].bits, 6'h01}, {1'b1, rows[k].bits, 5'h0a});
            tx_char(rows[k].d, rows[k].pe, par, 1'b1);
            rreg(3'h0);
            check(rd & 8'h01, 8'h01);
            rreg(3'h1);
            check(rd & 8'h70, 8'h00);
            apb(1'b0, `ASC_OFF_DATA, 8'h00);
            check(rd, rows[k].rx);
            apb(1'b1, `ASC_OFF_DATA, rows[k].d);
            i_modem.recv(got, nb, dv);
            check(got, rows[k].d);
            $display("row %0d done", k);
        end
        init(8'h44, 8'hc1, 8'hea);
        nb = 8;
        dv = 16;
        for (int i = 1; i < 5; i++)
            tx_char(8'h11 * i[7:0], 1'b0, 1'b0, 1'b1);
        foreach (ovr[i]) begin
            rreg(3'h1);
            check(rd & 8'h70, 8'h20);
            apb(1'b0, `ASC_OFF_DATA, 8'h00);
            check(rd, ovr[i]);
        end
        cmd(`ASC_CMD_ERR_RST);
        rreg(3'h1);
        check(rd & 8'h70, 8'h00);
        $display("overrun done");
        init(8'h47, 8'hc1, 8'hea);
        tx_char(8'h5a, 1'b1, 1'b1, 1'b1);
        rreg(3'h1);
        check(rd & 8'h70, 8'h10);
        cmd(`ASC_CMD_ERR_RST);
        tx_char(8'h5a, 1'b1, 1'b0, 1'b0);
        rreg(3'h1);
        check(rd & 8'h70, 8'h40);
        $display("errors done");
        init(8'h44, 8'he1, 8'hea);
        cmd(`ASC_CMD_RST_EXT);
        rreg(3'h0);
        check(rd & 8'h28, 8'h00);
        tx_char(8'h3c, 1'b0, 1'b0, 1'b1);
        apb(1'b1, `ASC_OFF_DATA, 8'h3c);
        repeat (300) @(posedge clk);
        rreg(3'h0);
        check({txd, rd[0]}, 2'b10);
        dcd_n <= 1'b0;
        repeat (8) @(posedge clk);
        cts_n <= 1'b0;
        i_modem.recv(got, nb, dv);
        check(got, 8'h3c);
        rreg(3'h0);
        check(rd & 8'h28, 8'h08);
        cmd(`ASC_CMD_RST_EXT);
        sync_n <= 1'b0;
        repeat (4) @(posedge clk);
        rreg(3'h0);
        check(rd & 8'h38, 8'h38);
        tx_char(8'h3c, 1'b0, 1'b0, 1'b1);
        rreg(3'h0);
        check(rd & 8'h01, 8'h01);
        $display("modem done");
        wreg(`ASC_REG_VEC, 8'h9c);
        wreg(`ASC_REG_OPT, 8'h17);
        rreg(3'h2);
        check(rd, 8'h9c);
        check(opts, 8'h17);
        apb(1'b0, 8'h08, 8'h00);
        check(err, 1'b1);
        rstn <= 1'b0;
        @(posedge clk);
        check({txd, rts_n, dtr_n, opts}, 11'h700);
        $display("misc done");
        give_verdict();
    end
endmodule
